// File: src/mbh_host.sv
// host-side controller that drives the companion device's bus pins
`timescale 1ns/1ns
module mbh_host (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [1:0] bus_mode,
   input wire logic ctl_a_style,
   input wire logic req_valid,
   input wire mbh_pkg::mbh_req_t req,
   output logic req_ready,
   output logic rsp_valid,
   output mbh_pkg::mbh_rsp_t rsp,
   input wire logic [7:0] lower_addr_data_port_i,
   output logic [7:0] lower_addr_data_port_o,
   output logic [7:0] lower_addr_data_port_oe,
   input wire logic [7:0] upper_addr_data_port_i,
   output logic [7:0] upper_addr_data_port_o,
   output logic [7:0] upper_addr_data_port_oe,
   output logic address_strobe_in,
   output logic control_input_a,
   output logic data_strobe_n,
   output logic program_select_n,
   output logic device_reset_n
);
   mbh_pkg::mbh_state_t state_q;
   logic [3:0] cnt_q;
   mbh_pkg::mbh_req_t cur_q;
   logic [15:0] din_s1_q, din_s2_q, din_s3_q;
   logic ctl_rw_q;

   // ***************************************
   // pad input synchroniser
   // ***************************************
   // only the third stage is sampled, and only once s2 and s3 agree
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         din_s1_q <= 16'h0000;
         din_s2_q <= 16'h0000;
         din_s3_q <= 16'h0000;
      end else begin
         din_s1_q <= {upper_addr_data_port_i, lower_addr_data_port_i};
         din_s2_q <= din_s1_q;
         din_s3_q <= din_s2_q;
      end
   end

   // ***************************************
   // sequencer
   // ***************************************
   // reset -> idle -> addr (strobe) -> turn -> strobe -> hold -> idle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= mbh_pkg::ST_RESET;
         cnt_q <= 4'h0;
         cur_q <= '0;
      end else begin
         case (state_q)
            mbh_pkg::ST_RESET: begin
               // keep the device in reset for a while after power-up
               if (cnt_q == mbh_pkg::RST_CYC - 4'h1) begin
                  state_q <= mbh_pkg::ST_IDLE;
                  cnt_q <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            mbh_pkg::ST_IDLE: begin
               if (req_valid) begin
                  cur_q <= req;
                  state_q <= mbh_pkg::ST_ADDR;
                  cnt_q <= 4'h0;
               end
            end
            mbh_pkg::ST_ADDR: begin
               if (cnt_q == mbh_pkg::ADDR_CYC - 4'h1) begin
                  state_q <= mbh_pkg::ST_TURN;
                  cnt_q <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            mbh_pkg::ST_TURN: begin
               state_q <= mbh_pkg::ST_STB;
            end
            mbh_pkg::ST_STB: begin
               // strobe width covers the three-stage sampling delay
               if (cnt_q == mbh_pkg::STB_CYC - 4'h1) begin
                  state_q <= mbh_pkg::ST_HOLD;
                  cnt_q <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            mbh_pkg::ST_HOLD: begin
               if (cnt_q == mbh_pkg::HOLD_CYC - 4'h1) begin
                  state_q <= mbh_pkg::ST_IDLE;
                  cnt_q <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            default: begin
               state_q <= mbh_pkg::ST_RESET;
               cnt_q <= 4'h0;
            end
         endcase
      end
   end

   // ***************************************
   // pin drivers
   // ***************************************
   // address phase: port wiring follows the host bus mode
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lower_addr_data_port_o <= 8'h00;
         upper_addr_data_port_o <= 8'h00;
         lower_addr_data_port_oe <= 8'h00;
         upper_addr_data_port_oe <= 8'h00;
      end else if (state_q == mbh_pkg::ST_IDLE && req_valid) begin
         lower_addr_data_port_oe <= 8'hff;
         upper_addr_data_port_oe <= 8'hff;
         if (bus_mode == mbh_pkg::MODE_BURST) begin
            lower_addr_data_port_o <= req.addr[11:4];
            upper_addr_data_port_o <= req.addr[19:12];
         end else begin
            lower_addr_data_port_o <= req.addr[7:0];
            upper_addr_data_port_o <= req.addr[15:8];
         end
      end else if (state_q == mbh_pkg::ST_TURN) begin
         // data phase: separate bus keeps address; mux swaps the low port, burst both ports to data
         if (bus_mode == mbh_pkg::MODE_MUX) begin
            lower_addr_data_port_o <= cur_q.wdata[7:0];
            lower_addr_data_port_oe <= {8{cur_q.write}};
         end else if (bus_mode == mbh_pkg::MODE_BURST) begin
            lower_addr_data_port_o <= cur_q.wdata[7:0];
            upper_addr_data_port_o <= cur_q.wdata[15:8];
            lower_addr_data_port_oe <= {8{cur_q.write}};
            upper_addr_data_port_oe <= {8{cur_q.write}};
         end
      end else if (state_q == mbh_pkg::ST_HOLD &&
                   cnt_q == mbh_pkg::HOLD_CYC - 4'h1) begin
         lower_addr_data_port_oe <= 8'h00;
         upper_addr_data_port_oe <= 8'h00;
      end
   end

   // strobes idle high except address_strobe_in, which idles low; rw select idles at read
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         address_strobe_in <= 1'b0;
         ctl_rw_q <= 1'b1;
         data_strobe_n <= 1'b1;
         program_select_n <= 1'b1;
      end else begin
         address_strobe_in <= (state_q == mbh_pkg::ST_IDLE && req_valid) ||
            (state_q == mbh_pkg::ST_ADDR &&
             cnt_q != mbh_pkg::ADDR_CYC - 4'h1);
         if (state_q == mbh_pkg::ST_IDLE && req_valid) begin
            ctl_rw_q <= ~req.write;
         end else if (state_q == mbh_pkg::ST_IDLE) begin
            ctl_rw_q <= 1'b1;
         end
         // data strobe on non-fetch reads, and on non-fetch writes in r/w select style, where
         // the select level alone cannot time the write
         data_strobe_n <= ~(state_q == mbh_pkg::ST_TURN &&
            !cur_q.code_fetch && (!cur_q.write ||
            ctl_a_style == mbh_pkg::CTL_A_RW_SELECT)) &
            (data_strobe_n | state_q != mbh_pkg::ST_STB |
             cnt_q == mbh_pkg::STB_CYC - 4'h1);
         // code fetch uses the program select line
         program_select_n <= ~(state_q == mbh_pkg::ST_TURN &&
            !cur_q.write && cur_q.code_fetch) &
            (program_select_n | state_q != mbh_pkg::ST_STB |
             cnt_q == mbh_pkg::STB_CYC - 4'h1);
      end
   end

   // write strobe pulses during the strobe phase in strobe style
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         control_input_a <= 1'b1;
      end else if (ctl_a_style == mbh_pkg::CTL_A_RW_SELECT) begin
         control_input_a <= (state_q == mbh_pkg::ST_IDLE && req_valid) ?
            ~req.write : ctl_rw_q;
      end else begin
         control_input_a <= ~((state_q == mbh_pkg::ST_TURN && cur_q.write) ||
            (state_q == mbh_pkg::ST_STB && cur_q.write &&
             cnt_q != mbh_pkg::STB_CYC - 4'h1));
      end
   end

   // device reset held low until our own power-up wait ends
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         device_reset_n <= 1'b0;
      end else begin
         device_reset_n <= (state_q != mbh_pkg::ST_RESET);
      end
   end

   // ***************************************
   // user answer
   // ***************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else begin
         req_ready <= (state_q == mbh_pkg::ST_HOLD &&
            cnt_q == mbh_pkg::HOLD_CYC - 4'h1) ||
            (state_q == mbh_pkg::ST_IDLE && !req_valid) ||
            (state_q == mbh_pkg::ST_RESET &&
             cnt_q == mbh_pkg::RST_CYC - 4'h1);
         rsp_valid <= state_q == mbh_pkg::ST_STB && !cur_q.write &&
            cnt_q == mbh_pkg::STB_CYC - 4'h1;
         // sampled at the strobe's end; s2 equal to s3 means stable
         if (state_q == mbh_pkg::ST_STB && !cur_q.write &&
             cnt_q == mbh_pkg::STB_CYC - 4'h1 && din_s2_q == din_s3_q) begin
            rsp.rdata <= (bus_mode == mbh_pkg::MODE_BURST) ? din_s3_q :
               {8'h00, din_s3_q[7:0]};
         end
      end
   end

   // ***************************************
   // checks
   // ***************************************
   // data strobe stays low for the whole strobe width, then lets go
   sequence strobe_pulse_s;
      !data_strobe_n [*5] ##1 data_strobe_n;
   endsequence

   addr_with_strobe_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      address_strobe_in |-> lower_addr_data_port_oe == 8'hff)
      else $error("address strobe without driven address");
   // a separate bus keeps the address on the ports through the read
   no_drive_read_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      ((!data_strobe_n && control_input_a) || !program_select_n) &&
      bus_mode != mbh_pkg::MODE_SEP |->
      lower_addr_data_port_oe == 8'h00)
      else $error("host drives port during read strobe");
   strobe_after_addr_a: assert property (@(posedge ref_clk)
      disable iff (rst) $fell(data_strobe_n) |->
      $past(address_strobe_in && lower_addr_data_port_oe[0], 3))
      else $error("read strobe without prior address phase");
   reset_held_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      !device_reset_n |-> address_strobe_in == 1'b0)
      else $error("bus active while device in reset");
   one_read_line_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      !(~data_strobe_n & ~program_select_n))
      else $error("both read lines active");
   strobe_width_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      $fell(data_strobe_n) |-> strobe_pulse_s)
      else $error("read strobe width wrong");
   write_data_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      (ctl_a_style == 1'b0 && !control_input_a && bus_mode == 2'h0) |->
      lower_addr_data_port_oe == 8'hff)
      else $error("write strobe without driven data");
   // only a read ends with an answer; r/w select writes strobe too
   rsp_timing_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      $rose(data_strobe_n) && control_input_a |-> rsp_valid)
      else $error("no answer at end of read");
endmodule

// File: include/mbh_pkg.sv
// package: bus modes, timing counts and request/answer carriers for the host
package mbh_pkg;
   // ***************************************
   // bus wiring modes
   // ***************************************
   localparam logic [1:0] MODE_MUX = 2'h0;   // low port carries a0-7 and data
   localparam logic [1:0] MODE_SEP = 2'h1;   // ports carry address only
   localparam logic [1:0] MODE_BURST = 2'h2; // a4-19 shared with d0-15
   // control_input_a style: write strobe or read/write select
   localparam logic CTL_A_WR_STROBE = 1'b0;
   localparam logic CTL_A_RW_SELECT = 1'b1;

   // ***************************************
   // strobe timing, in ref_clk cycles
   // ***************************************
   localparam int CLK_NS = 20;
   localparam int ADDR_NS = 40;   // address setup and strobe width
   localparam int STB_NS = 100;   // read/write strobe width
   localparam int HOLD_NS = 20;   // hold after strobe release
   localparam logic [3:0] ADDR_CYC = 4'((ADDR_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] STB_CYC = 4'((STB_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
   // reset pulse held on the device after our own reset
   localparam int RST_NS = 200;
   localparam logic [3:0] RST_CYC = 4'((RST_NS + CLK_NS - 1) / CLK_NS);

   // ***************************************
   // carriers
   // ***************************************
   typedef struct packed {
      logic write;        // 1 write, 0 read
      logic code_fetch;   // drive program_select_n instead of read strobe
      logic [19:0] addr;
      logic [15:0] wdata;
   } mbh_req_t;

   typedef struct packed {
      logic [15:0] rdata;
   } mbh_rsp_t;

   typedef enum logic [5:0] {
      ST_RESET = 6'h01,
      ST_IDLE = 6'h02,
      ST_ADDR = 6'h04,
      ST_TURN = 6'h08,
      ST_STB = 6'h10,
      ST_HOLD = 6'h20
   } mbh_state_t;
endpackage

// File: tb/mbh_dev_model.sv
// behavioural model of the companion device's bus port
`timescale 1ns/1ns
module mbh_dev_model (
   input wire logic ref_clk,
   input wire logic [1:0] bus_mode,
   input wire logic ctl_a_style,
   input wire logic [7:0] lo_bus,
   input wire logic [7:0] hi_bus,
   input wire logic address_strobe_in,
   input wire logic control_input_a,
   input wire logic data_strobe_n,
   input wire logic program_select_n,
   input wire logic device_reset_n,
   output logic [15:0] dout,
   output logic drive_lo,
   output logic drive_hi,
   output logic [19:0] addr_q,
   output logic [15:0] wdata_q,
   output int drive_cnt
);
   logic rd_act;
   logic wr_act;
   logic burst;
   // strobe decode feeds the internal logic; select doubles as read
   assign rd_act = (ctl_a_style ? control_input_a && !data_strobe_n
                    : !data_strobe_n)
                   || !program_select_n;
   assign wr_act = ctl_a_style ? !control_input_a && !data_strobe_n
                   : !control_input_a;
   assign burst = bus_mode == mbh_pkg::MODE_BURST;
   assign dout = addr_q[15:0] ^ 16'hc3a5;
   // only the upper half decodes to a function; elsewhere stay off the bus
   assign drive_lo = rd_act && addr_q[15] && device_reset_n
                     && bus_mode != mbh_pkg::MODE_SEP;
   assign drive_hi = drive_lo && burst;
   // sampled on the clock, not on strobe edges, to stay clear of races
   always @(posedge ref_clk or negedge device_reset_n) begin
      if (!device_reset_n) begin
         addr_q <= 20'h00000;
         wdata_q <= 16'h0000;
      end else begin
         if (address_strobe_in) begin
            addr_q <= burst ? {hi_bus, lo_bus, 4'h0}
                      : {4'h0, hi_bus, lo_bus};
         end
         if (wr_act) begin
            wdata_q <= burst ? {hi_bus, lo_bus} : {8'h00, lo_bus};
         end
      end
   end
   // counts cycles spent driving, so a missing release is visible
   initial drive_cnt = 0;
   always @(posedge ref_clk) begin
      if (drive_lo) begin
         drive_cnt <= drive_cnt + 1;
      end
   end
endmodule

// File: tb/mcu_bus_host_port_bench.sv
// self-checking bench for the host bus controller
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
   $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module mcu_bus_host_port_bench;
   typedef struct packed {
      logic [1:0] m;
      logic s;
      logic w;
      logic cf;
      logic [19:0] a;
      logic [15:0] d;
   } mbh_row_t;
   logic ref_clk, rst, ctl_a_style, req_valid, req_ready, rsp_valid;
   logic [1:0] bus_mode;
   mbh_pkg::mbh_req_t req;
   mbh_pkg::mbh_rsp_t rsp;
   logic [7:0] lo_i, lo_o, lo_oe, hi_i, hi_o, hi_oe, pat;
   logic address_strobe_in, control_input_a, data_strobe_n;
   logic program_select_n, device_reset_n, drive_lo, drive_hi;
   logic [15:0] dout, wdata_q;
   logic [19:0] addr_q;
   int drive_cnt, err_count, check_count, cyc, ale_w;
   mbh_row_t rows [10];
   mbh_host DUT (.ref_clk(ref_clk), .rst(rst), .bus_mode(bus_mode),
      .ctl_a_style(ctl_a_style), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
      .lower_addr_data_port_i(lo_i), .lower_addr_data_port_o(lo_o),
      .lower_addr_data_port_oe(lo_oe), .upper_addr_data_port_i(hi_i),
      .upper_addr_data_port_o(hi_o), .upper_addr_data_port_oe(hi_oe),
      .address_strobe_in(address_strobe_in),
      .control_input_a(control_input_a), .data_strobe_n(data_strobe_n),
      .program_select_n(program_select_n), .device_reset_n(device_reset_n));
   mbh_dev_model dev (.ref_clk(ref_clk), .bus_mode(bus_mode),
      .ctl_a_style(ctl_a_style), .lo_bus(lo_i), .hi_bus(hi_i),
      .address_strobe_in(address_strobe_in),
      .control_input_a(control_input_a), .data_strobe_n(data_strobe_n),
      .program_select_n(program_select_n), .device_reset_n(device_reset_n),
      .dout(dout), .drive_lo(drive_lo), .drive_hi(drive_hi),
      .addr_q(addr_q), .wdata_q(wdata_q), .drive_cnt(drive_cnt));
   // ***************************************
   // wire resolution and monitors
   // ***************************************
   // a floating bus toggles so a stale value can never pass for data
   assign pat = cyc[0] ? 8'h55 : 8'haa;
   assign lo_i = (lo_oe & lo_o) | (~lo_oe & (drive_lo ? dout[7:0] : pat));
   assign hi_i = (hi_oe & hi_o) | (~hi_oe & (drive_hi ? dout[15:8] : pat));
   always #10 ref_clk = ~ref_clk;
   // timeout and address strobe width
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      ale_w <= address_strobe_in ? ale_w + 1 : 0;
      if (!address_strobe_in && ale_w != 0 && !rst)
         `CHK(ale_w, int'(mbh_pkg::ADDR_CYC))
      if (cyc == 3000) begin
         err_count++;
         end_of_test();
      end
   end
   // host must have let go of the port whenever the device drives it
   always @(negedge ref_clk) begin
      if (drive_lo || drive_hi)
         `CHK({lo_oe & {8{drive_lo}}, hi_oe & {8{drive_hi}}}, 16'h0000)
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // one whole transfer, then compare what the device saw or returned
   task automatic run(input mbh_row_t r);
      int n;
      int dc;
      logic [19:0] ea;
      logic [15:0] dv;
      logic b;
      b = r.m == mbh_pkg::MODE_BURST;
      ea = b ? {r.a[19:4], 4'h0} : {4'h0, r.a[15:0]};
      dv = ea[15:0] ^ 16'hc3a5;
      dc = drive_cnt;
      @(posedge ref_clk);
      bus_mode <= r.m;
      ctl_a_style <= r.s;
      req <= '{write: r.w, code_fetch: r.cf, addr: r.a, wdata: r.d};
      req_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 40);
      `CHK(n < 40, 1'b1)
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while ((r.w ? req_ready : rsp_valid) !== 1'b1 && n < 40);
      `CHK(n < 40, 1'b1)
      `CHK(addr_q, ea)
      if (r.w && r.m != mbh_pkg::MODE_SEP)
         `CHK(wdata_q, b ? r.d : {8'h00, r.d[7:0]})
      if (!r.w && ea[15])
         `CHK(rsp.rdata, b ? dv : {8'h00, dv[7:0]})
      if (!r.w && !ea[15])
         `CHK(drive_cnt, dc)
   endtask
   initial begin
      rows = '{'{2'h0, 1'b0, 1'b1, 1'b0, 20'h08a5c, 16'h0037},
               '{2'h0, 1'b0, 1'b0, 1'b0, 20'h08a5c, 16'h0000},
               '{2'h0, 1'b1, 1'b1, 1'b0, 20'h0f00f, 16'h00e1},
               '{2'h0, 1'b1, 1'b0, 1'b1, 20'h0ff00, 16'h0000},
               '{2'h1, 1'b0, 1'b1, 1'b0, 20'h09123, 16'h1111},
               '{2'h1, 1'b1, 1'b1, 1'b0, 20'h01234, 16'h2222},
               '{2'h2, 1'b0, 1'b1, 1'b0, 20'h98760, 16'hbeef},
               '{2'h2, 1'b1, 1'b0, 1'b0, 20'h4c3b0, 16'h0000},
               '{2'h2, 1'b0, 1'b0, 1'b1, 20'h8ffff, 16'h0000},
               '{2'h0, 1'b0, 1'b0, 1'b0, 20'h00123, 16'h0000}};
      ref_clk = 1'b0;
      rst = 1'b1;
      bus_mode = 2'h0;
      ctl_a_style = 1'b0;
      req_valid = 1'b0;
      req = '0;
      cyc = 0;
      ale_w = 0;
      err_count = 0;
      check_count = 0;
      repeat (4) @(posedge ref_clk);
      `CHK({device_reset_n, req_ready, lo_oe, hi_oe}, 18'h00000)
      rst <= 1'b0;
      repeat (int'(mbh_pkg::RST_CYC) - 1) begin
         @(posedge ref_clk);
         `CHK({device_reset_n, req_ready}, 2'h0)
      end
      foreach (rows[i]) run(rows[i]);
      // reset landing in mid-transfer must drop port enables, address strobe and read lines to idle and assert device reset
      @(posedge ref_clk);
      req <= '{write: 1'b1, code_fetch: 1'b0, addr: 20'h08800, wdata: 16'h5a};
      req_valid <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b1;
      req_valid <= 1'b0;
      @(negedge ref_clk);
      `CHK({lo_oe, hi_oe, address_strobe_in}, 17'h00000)
      `CHK({data_strobe_n, program_select_n, device_reset_n}, 3'h6)
      @(posedge ref_clk);
      rst <= 1'b0;
      run(rows[1]);
      end_of_test();
   end
endmodule
